// [verilog/sleep_pkg.sv]
`default_nettype none
package sleep_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] MCU_CTRL_OFS   = 8'h00;
    localparam logic [7:0] CFG_OFS        = 8'h04;
    localparam logic [7:0] STATUS_OFS     = 8'h08;

    // Control register layout and reset
    localparam int         SE_BIT         = 5;
    localparam int         SM_LSB         = 3;
    localparam int         SM_MSB         = 4;
    localparam int         RSV_BIT        = 2;
    localparam logic [7:0] MCU_CTRL_RST   = 8'h00;
    localparam logic [7:0] MCU_CTRL_WMASK = 8'h38;

    // Configuration register layout and reset
    localparam int         ADC_ON_BIT     = 0;
    localparam int         CMP_OFF_BIT    = 1;
    localparam int         CMP_REF_BIT    = 2;
    localparam int         LVL_SENSE_BIT  = 3;
    localparam logic [7:0] CFG_RST        = 8'h00;
    localparam logic [7:0] CFG_WMASK      = 8'h0F;

    // Wake timing in clock cycles
    localparam int         HALT_CYCLES    = 4;
    localparam int         STARTUP_DEF    = 6;
    localparam int         TIMER_W        = 16;

    // Bus responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        MODE_IDLE  = 2'h0,
        MODE_NOISE = 2'h1,
        MODE_PDOWN = 2'h2,
        MODE_RSVD  = 2'h3
    } sleep_kind_type;

    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_SLEEP  = 4'h2,
        ST_START  = 4'h4,
        ST_HALT   = 4'h8
    } pm_state_type;

endpackage
`default_nettype wire

// [verilog/halt_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module halt_timer #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    logic [W-1:0] cnt_q;

    // Down counter, done in the last counted cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign done = (cnt_q == W'(1));
endmodule
`default_nettype wire

// [verilog/wake_qualify.sv]
`timescale 1ns/1ps
`default_nettype none
module wake_qualify
    import sleep_pkg::*;
(
    input  wire sleep_kind_type mode,
    input  wire logic           level_sense,
    input  wire logic           irq_ext,
    input  wire logic           irq_pin_change,
    input  wire logic           irq_mem_ready,
    input  wire logic           irq_adc,
    input  wire logic           irq_other_io,
    input  wire logic           irq_wdt,
    input  wire logic           rst_ext,
    input  wire logic           rst_wdt,
    input  wire logic           rst_bod,
    output logic                wake_irq,
    output logic                wake_rst
);
    logic ext_ok;

    // Wake sources allowed by the latched sleep kind
    always_comb begin
        ext_ok = irq_ext & (level_sense | (mode == MODE_IDLE));
        case (mode)
            MODE_IDLE: begin
                wake_irq = irq_ext | irq_pin_change | irq_mem_ready | irq_adc | irq_other_io | irq_wdt;
            end
            MODE_NOISE: begin
                wake_irq = ext_ok | irq_pin_change | irq_mem_ready | irq_adc | irq_wdt;
            end
            MODE_PDOWN: begin
                wake_irq = ext_ok | irq_pin_change | irq_wdt;
            end
            default: begin
                wake_irq = 1'b0;
            end
        endcase
    end

    // Every reset source wakes in every mode
    assign wake_rst = rst_ext | rst_wdt | rst_bod;
endmodule
`default_nettype wire

// [verilog/sleep_mode_controller.sv]
// Functional notes
// - Sleep only when enable bit five set
// - Bits 4:3 pick idle, noise, power-down
// - Halt four cycles after start-up, then handler
// - Register file and memory kept intact
// - Reset wakes, execution restarts at vector
// - Idle stops only CPU and flash clocks
// - Idle wakes on any enabled interrupt
// - Idle or noise entry starts a conversion
// - Noise mode keeps only converter clock, oscillator
// - Noise mode wakes on listed sources only
// - Power-down stops oscillator and all clocks
// - Power-down wakes on resets, level, pins, watchdog
// - External line wakes deep modes only level-sensed
// - Input buffers off when I/O, converter stopped; here only in power-down sleep, wake pins kept
// - Converter stays on; re-enable means extended conversion
// - Power-down turns comparator off unless reference used
// - Watchdog and brown-out never gated by sleep
// - Reference on only when something needs it
// - Control bit two always reads zero
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller
    import sleep_pkg::*;
#(
    parameter int ADDR_W          = 8,
    parameter int PINS            = 6,
    parameter int STARTUP_CYCLES  = STARTUP_DEF
) (
    input  wire logic              REF_CLK,
    input  wire logic              SRST,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    input  wire logic              SLEEP_EXEC,
    input  wire logic              IRQ_EXT,
    input  wire logic              IRQ_PIN_CHANGE,
    input  wire logic              IRQ_MEM_READY,
    input  wire logic              IRQ_ADC,
    input  wire logic              IRQ_OTHER_IO,
    input  wire logic              IRQ_WDT,
    input  wire logic              RST_EXT,
    input  wire logic              RST_WDT,
    input  wire logic              RST_BOD,
    input  wire logic              BOD_FUSE_EN,
    input  wire logic              WDT_ACTIVE,
    input  wire logic              ADC_CONV_DONE,
    input  wire logic [PINS-1:0]   WAKE_PIN_MASK,
    output logic                   CPU_CLK_EN,
    output logic                   FLASH_CLK_EN,
    output logic                   IO_CLK_EN,
    output logic                   ADC_CLK_EN,
    output logic                   OSC_EN,
    output logic                   CORE_HALT,
    output logic                   IRQ_RUN,
    output logic                   RESET_WAKE,
    output logic                   ADC_EN,
    output logic                   ADC_START,
    output logic                   ADC_EXTENDED,
    output logic                   COMP_EN,
    output logic                   VREF_EN,
    output logic                   BOD_EN,
    output logic                   WDT_EN,
    output logic [PINS-1:0]        INPUT_BUF_EN
);
    localparam logic [TIMER_W-1:0] HALT_LOAD  = TIMER_W'(HALT_CYCLES);
    localparam logic [TIMER_W-1:0] START_LOAD = TIMER_W'(STARTUP_CYCLES);

    logic [7:0]        mcu_q;
    logic [7:0]        cfg_q;
    pm_state_type      state_q;
    pm_state_type      state_d;
    sleep_kind_type    mode_q;
    sleep_kind_type    mode_d;
    sleep_kind_type    sm_field;
    logic              wr_fire;
    logic              rd_fire;
    logic [ADDR_W-1:0] aw_word;
    logic [ADDR_W-1:0] ar_word;
    logic [31:0]       rd_data_d;
    logic [1:0]        rd_resp_d;
    logic [1:0]        wr_resp_d;
    logic              sleep_go;
    logic              wake_irq;
    logic              wake_rst;
    logic              tmr_load;
    logic              tmr_done;
    logic              deep_sleep;
    logic              cmp_on_d;
    logic              adc_on_prev_q;
    logic              cpu_d;
    logic              io_d;
    logic              adc_d;
    logic              osc_d;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    // Write channel: address and data taken together, one response
    assign wr_fire       = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
    assign S_AXI_AWREADY = wr_fire;
    assign S_AXI_WREADY  = wr_fire;
    assign aw_word       = {S_AXI_AWADDR[ADDR_W-1:2], 2'b00};
    assign ar_word       = {S_AXI_ARADDR[ADDR_W-1:2], 2'b00};
    assign rd_fire       = S_AXI_ARVALID & ~S_AXI_RVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;

    // Write response code from the decoded address
    always_comb begin
        if (aw_word == ADDR_W'(MCU_CTRL_OFS) || aw_word == ADDR_W'(CFG_OFS) || aw_word == ADDR_W'(STATUS_OFS)) begin
            wr_resp_d = RESP_OKAY;
        end else begin
            wr_resp_d = RESP_SLVERR;
        end
    end

    // Write response handshake
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_resp_d;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Control register; hardware never touches the enable bit
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            mcu_q <= MCU_CTRL_RST;
        end else if (wr_fire && S_AXI_WSTRB[0] && aw_word == ADDR_W'(MCU_CTRL_OFS)) begin
            mcu_q <= S_AXI_WDATA[7:0] & MCU_CTRL_WMASK;
        end
    end

    // Converter, comparator and sense configuration
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cfg_q <= CFG_RST;
        end else if (wr_fire && S_AXI_WSTRB[0] && aw_word == ADDR_W'(CFG_OFS)) begin
            cfg_q <= S_AXI_WDATA[7:0] & CFG_WMASK;
        end
    end

    // Read data mux
    always_comb begin
        rd_data_d = 32'h0000_0000;
        rd_resp_d = RESP_OKAY;
        case (ar_word)
            ADDR_W'(MCU_CTRL_OFS): begin
                rd_data_d = {24'h00_0000, mcu_q};
            end
            ADDR_W'(CFG_OFS): begin
                rd_data_d = {24'h00_0000, cfg_q};
            end
            ADDR_W'(STATUS_OFS): begin
                rd_data_d = {25'h000_0000, ADC_EXTENDED, mode_q, state_q};
            end
            default: begin
                rd_resp_d = RESP_SLVERR;
            end
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (rd_fire) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_data_d;
            S_AXI_RRESP  <= rd_resp_d;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Sleep entry qualification
    assign sm_field = sleep_kind_type'(mcu_q[SM_MSB:SM_LSB]);
    assign sleep_go = (state_q == ST_ACTIVE) && SLEEP_EXEC && mcu_q[SE_BIT] && (sm_field != MODE_RSVD);
    assign mode_d   = sleep_go ? sm_field : mode_q;

    wake_qualify u_wake (
        .mode           (mode_q),
        .level_sense    (cfg_q[LVL_SENSE_BIT]),
        .irq_ext        (IRQ_EXT),
        .irq_pin_change (IRQ_PIN_CHANGE),
        .irq_mem_ready  (IRQ_MEM_READY),
        .irq_adc        (IRQ_ADC),
        .irq_other_io   (IRQ_OTHER_IO),
        .irq_wdt        (IRQ_WDT),
        .rst_ext        (RST_EXT),
        .rst_wdt        (RST_WDT),
        .rst_bod        (RST_BOD),
        .wake_irq       (wake_irq),
        .wake_rst       (wake_rst)
    );

    // Sleep sequencing: sleep, oscillator start-up, wake halt
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_ACTIVE: begin
                if (sleep_go) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_rst) begin
                    state_d = ST_ACTIVE;
                end else if (wake_irq) begin
                    state_d = (mode_q == MODE_PDOWN) ? ST_START : ST_HALT;
                end
            end
            ST_START: begin
                if (wake_rst) begin
                    state_d = ST_ACTIVE;
                end else if (tmr_done) begin
                    state_d = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_rst || tmr_done) begin
                    state_d = ST_ACTIVE;
                end
            end
            default: begin
                state_d = ST_ACTIVE;
            end
        endcase
    end

    // State and latched sleep kind
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_q <= ST_ACTIVE;
            mode_q  <= MODE_IDLE;
        end else begin
            state_q <= state_d;
            mode_q  <= mode_d;
        end
    end

    // Shared timer for start-up and halt counts
    assign tmr_load = (state_d != state_q) && (state_d == ST_START || state_d == ST_HALT);

    halt_timer #(
        .W (TIMER_W)
    ) u_timer (
        .clk   (REF_CLK),
        .srst  (SRST),
        .load  (tmr_load),
        .value ((state_d == ST_START) ? START_LOAD : HALT_LOAD),
        .done  (tmr_done)
    );

    // Clock domain enables for the coming state
    always_comb begin
        cpu_d = 1'b1;
        io_d  = 1'b1;
        adc_d = 1'b1;
        osc_d = 1'b1;
        case (state_d)
            ST_SLEEP: begin
                cpu_d = 1'b0;
                io_d  = (mode_d == MODE_IDLE);
                adc_d = (mode_d != MODE_PDOWN);
                osc_d = (mode_d != MODE_PDOWN);
            end
            ST_START: begin
                cpu_d = 1'b0;
                io_d  = 1'b0;
                adc_d = 1'b0;
            end
            ST_HALT: begin
                cpu_d = 1'b0;
            end
            default: begin
                cpu_d = 1'b1;
            end
        endcase
    end

    // Registered clock enables and core halt
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            CPU_CLK_EN   <= 1'b1;
            FLASH_CLK_EN <= 1'b1;
            IO_CLK_EN    <= 1'b1;
            ADC_CLK_EN   <= 1'b1;
            OSC_EN       <= 1'b1;
            CORE_HALT    <= 1'b0;
        end else begin
            CPU_CLK_EN   <= cpu_d;
            FLASH_CLK_EN <= cpu_d;
            IO_CLK_EN    <= io_d;
            ADC_CLK_EN   <= adc_d;
            OSC_EN       <= osc_d;
            CORE_HALT    <= (state_d != ST_ACTIVE);
        end
    end

    // Wake pulses toward the core, conversion start on sleep entry
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            IRQ_RUN    <= 1'b0;
            RESET_WAKE <= 1'b0;
            ADC_START  <= 1'b0;
        end else begin
            IRQ_RUN    <= (state_q == ST_HALT) && tmr_done && !wake_rst;
            RESET_WAKE <= (state_q != ST_ACTIVE) && wake_rst;
            ADC_START  <= sleep_go && cfg_q[ADC_ON_BIT] && (sm_field != MODE_PDOWN);
        end
    end

    // Extended conversion flag: set on re-enable wins over done
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            adc_on_prev_q <= 1'b0;
            ADC_EXTENDED  <= 1'b1;
        end else begin
            adc_on_prev_q <= cfg_q[ADC_ON_BIT];
            if (cfg_q[ADC_ON_BIT] && !adc_on_prev_q) begin
                ADC_EXTENDED <= 1'b1;
            end else if (ADC_CONV_DONE) begin
                ADC_EXTENDED <= 1'b0;
            end
        end
    end

    // Analog enables, never gated by sleep except the comparator
    assign deep_sleep = (state_d == ST_SLEEP) && (mode_d == MODE_PDOWN);
    assign cmp_on_d   = !cfg_q[CMP_OFF_BIT] && !(deep_sleep && !cfg_q[CMP_REF_BIT]);

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ADC_EN  <= 1'b0;
            COMP_EN <= 1'b0;
            VREF_EN <= 1'b0;
            BOD_EN  <= 1'b0;
            WDT_EN  <= 1'b0;
        end else begin
            ADC_EN  <= cfg_q[ADC_ON_BIT];
            COMP_EN <= cmp_on_d;
            VREF_EN <= BOD_FUSE_EN | (cmp_on_d & cfg_q[CMP_REF_BIT]) | cfg_q[ADC_ON_BIT];
            BOD_EN  <= BOD_FUSE_EN;
            WDT_EN  <= WDT_ACTIVE;
        end
    end

    // Per-pin input buffer enables; wake pins stay live
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_ff @(posedge REF_CLK) begin
            if (SRST) begin
                INPUT_BUF_EN[i] <= 1'b1;
            end else begin
                INPUT_BUF_EN[i] <= !deep_sleep || WAKE_PIN_MASK[i];
            end
        end
    end

    // Pin mask one cycle ago, matched to the registered buffers
    logic [PINS-1:0] wake_mask_q;
    always_ff @(posedge REF_CLK) begin
        wake_mask_q <= WAKE_PIN_MASK;
    end

    sequence s_sleep_enter;
        state_q == ST_SLEEP && $past(state_q) == ST_ACTIVE;
    endsequence

    sequence s_halt_enter;
        state_q == ST_HALT && $past(state_q) != ST_HALT;
    endsequence

    property p_halt_four;
        @(posedge REF_CLK) disable iff (SRST || wake_rst)
        s_halt_enter |-> (CORE_HALT && !CPU_CLK_EN)[*4] ##1 (state_q == ST_ACTIVE && IRQ_RUN);
    endproperty

    a_sleep_needs_se: assert property (s_sleep_enter |-> $past(mcu_q[SE_BIT]) && $past(SLEEP_EXEC))
        else $error("sleep entered without enable");
    a_reserved_kind: assert property (state_q == ST_ACTIVE && sm_field == MODE_RSVD |=> state_q == ST_ACTIVE)
        else $error("reserved sleep kind entered sleep");
    a_halt_four: assert property (p_halt_four)
        else $error("wake halt not four cycles");
    a_reset_wake: assert property (state_q == ST_SLEEP && wake_rst |=> state_q == ST_ACTIVE && RESET_WAKE && !IRQ_RUN)
        else $error("reset did not wake");
    a_idle_clocks: assert property (state_q == ST_SLEEP && mode_q == MODE_IDLE |-> !CPU_CLK_EN && !FLASH_CLK_EN && IO_CLK_EN && ADC_CLK_EN && OSC_EN)
        else $error("idle clock gating wrong");
    a_adc_autostart: assert property (s_sleep_enter and (mode_q != MODE_PDOWN && $past(cfg_q[ADC_ON_BIT])) |-> ADC_START)
        else $error("no conversion on sleep entry");
    a_noise_clocks: assert property (state_q == ST_SLEEP && mode_q == MODE_NOISE |-> !IO_CLK_EN && !CPU_CLK_EN && ADC_CLK_EN && OSC_EN)
        else $error("noise mode clock gating wrong");
    a_pdown_clocks: assert property (state_q == ST_SLEEP && mode_q == MODE_PDOWN |-> !OSC_EN && !IO_CLK_EN && !ADC_CLK_EN && !CPU_CLK_EN)
        else $error("power-down clocks running");
    a_pdown_no_mem: assert property (state_q == ST_SLEEP && mode_q == MODE_PDOWN && IRQ_MEM_READY && !IRQ_EXT && !IRQ_PIN_CHANGE && !IRQ_WDT && !wake_rst |=> state_q == ST_SLEEP)
        else $error("power-down woke on illegal source");
    a_inbuf_off: assert property (state_q == ST_SLEEP && mode_q == MODE_PDOWN |-> INPUT_BUF_EN == wake_mask_q)
        else $error("input buffers not gated");
    a_comp_off: assert property (state_q == ST_SLEEP && mode_q == MODE_PDOWN && !$past(cfg_q[CMP_REF_BIT]) |-> !COMP_EN)
        else $error("comparator on in power-down");
    a_vref_need: assert property (VREF_EN |-> $past(BOD_FUSE_EN) || $past(cfg_q[ADC_ON_BIT]) || (COMP_EN && $past(cfg_q[CMP_REF_BIT])))
        else $error("reference on without user");
    a_se_kept: assert property (state_q != ST_SLEEP && $past(state_q) == ST_SLEEP && !$past(wr_fire) |-> mcu_q[SE_BIT] == $past(mcu_q[SE_BIT]))
        else $error("hardware changed sleep enable");
    a_rsvd_zero: assert property (rd_fire && ar_word == ADDR_W'(MCU_CTRL_OFS) |=> !S_AXI_RDATA[RSV_BIT])
        else $error("reserved control bit set");
endmodule
`default_nettype wire

// [sim/irq_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [5:0] set,
    input  wire logic       done,
    output logic      [5:0] irq
);
    // Pending level stays up until the handler runs or reset
    always_ff @(posedge clk) begin
        if (srst || done) begin
            irq <= 6'h00;
        end else begin
            irq <= irq | set;
        end
    end
endmodule
`default_nettype wire

// [sim/sleep_mode_controller_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller_bench;
    import sleep_pkg::*;
    localparam int SU = 2;
    logic        clk, srst, awv, wv, br, arv, rr, se, cdone, on;
    logic [2:0]  rst;
    logic [7:0]  aw, ar;
    logic [31:0] wd;
    logic [5:0]  set, want;
    wire  [5:0]  irq, ibuf;
    wire  [4:0]  ce;
    wire  [31:0] rdata;
    wire  [1:0]  bresp, rresp;
    wire         awr, wrdy, bv, arr, rv, halt, irun, rwake, adce, adcs, adcx, cmp, vref, bod, wdt;
    int          err_count, n_compared, n;

    sleep_mode_controller #(.STARTUP_CYCLES(SU)) dut (
        .REF_CLK(clk), .SRST(srst), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .SLEEP_EXEC(se),
        .IRQ_EXT(irq[5]), .IRQ_PIN_CHANGE(irq[4]), .IRQ_MEM_READY(irq[3]), .IRQ_ADC(irq[2]),
        .IRQ_OTHER_IO(irq[1]), .IRQ_WDT(irq[0]), .RST_EXT(rst[0]), .RST_WDT(rst[1]), .RST_BOD(rst[2]),
        .BOD_FUSE_EN(on), .WDT_ACTIVE(on), .ADC_CONV_DONE(cdone), .WAKE_PIN_MASK(6'h05),
        .CPU_CLK_EN(ce[4]), .FLASH_CLK_EN(ce[3]), .IO_CLK_EN(ce[2]), .ADC_CLK_EN(ce[1]), .OSC_EN(ce[0]),
        .CORE_HALT(halt), .IRQ_RUN(irun), .RESET_WAKE(rwake), .ADC_EN(adce), .ADC_START(adcs),
        .ADC_EXTENDED(adcx), .COMP_EN(cmp), .VREF_EN(vref), .BOD_EN(bod), .WDT_EN(wdt), .INPUT_BUF_EN(ibuf));

    irq_source_model partner (.clk(clk), .srst(srst), .set(set), .done(irun | rwake), .irq(irq));

    // Free-running clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    task automatic wrap_up();
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return awr & wrdy;
            1: return bv;
            2: return arr;
            3: return rv;
            4: return |(irq & want);
            default: return irun;
        endcase
    endfunction

    // Bounded wait, sampled mid-cycle; leaves at the edge that takes it
    task automatic hold(input int k);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pick(k) !== 1'h1 && n < 60);
        if (n >= 60) begin
            err_count++;
            wrap_up();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        aw <= a;
        wd <= {24'h000000, d};
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        hold(0);
        awv <= 1'h0;
        wv <= 1'h0;
        hold(1);
        chk("bresp", 32'(er), 32'(bresp));
        br <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        ar <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        hold(2);
        arv <= 1'h0;
        hold(3);
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        rr <= 1'h0;
    endtask

    // One sleep instruction; returns just after the edge that takes it
    task automatic slp();
        @(posedge clk);
        se <= 1'h1;
        @(posedge clk);
        se <= 1'h0;
        #1;
    endtask

    // Raise interrupts and count cycles from wake to handler start
    task automatic wake(input logic [5:0] b, input int e);
        want = b;
        @(posedge clk);
        set <= b;
        @(posedge clk);
        set <= 6'h00;
        hold(4);
        hold(5);
        chk("wake_cycles", 32'(e), 32'(n));
    endtask

    // Raise sources the mode must ignore; the part stays asleep
    task automatic stray(input logic [5:0] b);
        @(posedge clk);
        set <= b;
        @(posedge clk);
        set <= 6'h00;
        repeat (8) @(posedge clk);
        #1;
        chk("halt", 32'h1, 32'(halt));
    endtask

    // Sleep, then let one reset source wake the part
    task automatic rwk(input logic [2:0] b);
        slp();
        @(posedge clk);
        rst <= b;
        @(posedge clk);
        rst <= 3'h0;
        #1;
        chk("reset_wake", 32'h2, 32'({rwake, halt}));
    endtask

    // Main sequence
    initial begin
        err_count = 0;
        n_compared = 0;
        {srst, awv, wv, br, arv, rr, se, cdone, on} = 9'h100;
        {aw, ar, wd, set, want, rst} = '0;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        on <= 1'h1;
        rd(MCU_CTRL_OFS, 32'h0, RESP_OKAY);
        wr(MCU_CTRL_OFS, 8'hFF, RESP_OKAY);
        rd(MCU_CTRL_OFS, 32'h38, RESP_OKAY);
        wr(8'h0C, 8'h01, RESP_SLVERR);
        rd(8'h0C, 32'h0, RESP_SLVERR);
        wr(MCU_CTRL_OFS, 8'h10, RESP_OKAY);
        slp();
        chk("halt", 32'h0, 32'(halt));
        wr(MCU_CTRL_OFS, 8'h38, RESP_OKAY);
        slp();
        chk("halt", 32'h0, 32'(halt));
        wr(CFG_OFS, 8'h01, RESP_OKAY);
        wr(MCU_CTRL_OFS, 8'h20, RESP_OKAY);
        slp();
        chk("clk_en", 32'h07, 32'(ce));
        chk("adc_start", 32'h1, 32'(adcs));
        wake(6'h02, HALT_CYCLES + 1);
        rd(MCU_CTRL_OFS, 32'h20, RESP_OKAY);
        wr(MCU_CTRL_OFS, 8'h28, RESP_OKAY);
        slp();
        chk("clk_en", 32'h03, 32'(ce));
        chk("adc_start", 32'h1, 32'(adcs));
        stray(6'h22);
        wake(6'h04, HALT_CYCLES + 1);
        @(posedge clk);
        cdone <= 1'h1;
        @(posedge clk);
        cdone <= 1'h0;
        #1;
        chk("adc_extended", 32'h0, 32'(adcx));
        wr(CFG_OFS, 8'h00, RESP_OKAY);
        wr(CFG_OFS, 8'h09, RESP_OKAY);
        wr(MCU_CTRL_OFS, 8'h30, RESP_OKAY);
        slp();
        chk("clk_en", 32'h00, 32'(ce));
        chk("input_buf", 32'h05, 32'(ibuf));
        chk("analog_en", 32'h2F, 32'({adcx, cmp, adce, bod, wdt, vref}));
        stray(6'h0A);
        wake(6'h20, HALT_CYCLES + 1 + SU);
        rwk(3'h1);
        rwk(3'h2);
        rwk(3'h4);
        wr(MCU_CTRL_OFS, 8'h00, RESP_OKAY);
        wrap_up();
    end
endmodule
`default_nettype wire
